// ---- pkg/acfd_cfg.svh ----
/*
 Framing and decoding constants for the API command frame decoder.
 Assumes it is included by its bare name wherever a count or code is used.
*/
`ifndef ACFD_CFG_SVH
`define ACFD_CFG_SVH

// Frame delimiter and checksum target
`define ACFD_DELIM 8'h7E
`define ACFD_CSUM_OK 8'hFF
// Frame type codes
`define ACFD_TYPE_IMM 8'h08
`define ACFD_TYPE_QUE 8'h09
`define ACFD_TYPE_SMS 8'h1F
`define ACFD_TYPE_RESP 8'h88
`define ACFD_TYPE_TXST 8'h89
// Two ASCII characters of the apply-changes command
`define ACFD_NAME_APPLY 16'h4143
// Byte positions inside frame data
`define ACFD_IDX_TYPE 16'h0000
`define ACFD_IDX_ID 16'h0001
`define ACFD_IDX_NAME_HI 16'h0002
`define ACFD_IDX_NAME_LO 16'h0003
`define ACFD_PAR_HDR 16'h0004
`define ACFD_NUM_FIRST 16'h0003
`define ACFD_SMS_HDR 16'h0017
// Field sizes
`define ACFD_NUM_BYTES 20
`define ACFD_BODY_MAX 160

`endif

// ---- pkg/acfd_pkg.sv ----
/*
 Types shared by both ends of the API command frame link.
 Assumes acfd_cfg.svh is on the include path.
*/
`default_nettype none
package acfd_pkg;
   // Receive framing states of the device end
   typedef enum logic [2:0] {
      ACFD_RX_IDLE = 3'b000,
      ACFD_RX_LHI = 3'b001,
      ACFD_RX_LLO = 3'b010,
      ACFD_RX_DATA = 3'b011,
      ACFD_RX_CSUM = 3'b100
   } acfd_rx_e;

   // Transmit framing states of the host end
   typedef enum logic [2:0] {
      ACFD_TX_IDLE = 3'b000,
      ACFD_TX_DELIM = 3'b001,
      ACFD_TX_LHI = 3'b010,
      ACFD_TX_LLO = 3'b011,
      ACFD_TX_DATA = 3'b100,
      ACFD_TX_CSUM = 3'b101
   } acfd_tx_e;

   // One byte on the link
   typedef logic [7:0] acfd_byte_t;
endpackage
`default_nettype wire

// ---- pkg/acfd_if.sv ----
/*
 Byte stream link between the host frame builder and the device decoder.
 Assumes both ends run on the same clock; valid and ready handshake.
*/
`timescale 1ns/1ns
`default_nettype none
interface acfd_if;
   logic byte_valid; // Host offers a byte
   logic [7:0] byte_data; // Byte being offered
   logic byte_ready; // Device can take a byte

   // Device end takes bytes
   modport dev (input byte_valid, input byte_data, output byte_ready);
   // Host end sends bytes
   modport host (output byte_valid, output byte_data, input byte_ready);
endinterface
`default_nettype wire

// ---- hdl/acfd_host.sv ----
/*
 Host end: wraps caller frame data into delimited, checksummed frames.
 Assumes the caller supplies the frame data bytes in the documented
 field order and that the device end sits on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acfd_cfg.svh"
module acfd_host
   import acfd_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   acfd_if.host link,
   input wire logic start_in,
   input wire logic [15:0] len_in,
   input wire logic usr_valid_in,
   input wire logic [7:0] usr_data_in,
   output logic usr_ready_out,
   output logic busy_out
);
   acfd_tx_e st_q; // Framing state
   logic [15:0] len_q; // Frame data count to announce
   logic [15:0] left_q; // Data bytes still to send
   logic [7:0] sum_q; // Running sum of frame data
   logic out_v_q; // Link byte held
   logic [7:0] out_d_q; // Link byte value
   logic rdy_q; // Caller may hand a byte
   logic busy_q;

   // Byte accepted by the device, and an empty output slot
   wire sent = out_v_q && link.byte_ready;
   wire slot = !out_v_q;
   wire take_usr = slot && rdy_q && usr_valid_in;

   assign link.byte_valid = out_v_q;
   assign link.byte_data = out_d_q;
   assign usr_ready_out = rdy_q;
   assign busy_out = busy_q;

   // Frame builder: one byte in the slot at a time
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_q <= ACFD_TX_IDLE;
         len_q <= 16'h0000;
         left_q <= 16'h0000;
         sum_q <= 8'h00;
         out_v_q <= 1'b0;
         out_d_q <= 8'h00;
         rdy_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (sent) begin
            out_v_q <= 1'b0;
         end
         case (st_q)
            ACFD_TX_IDLE: begin
               if (start_in) begin
                  len_q <= len_in;
                  left_q <= len_in;
                  sum_q <= 8'h00;
                  st_q <= ACFD_TX_DELIM;
                  busy_q <= 1'b1;
               end
            end
            ACFD_TX_DELIM: begin
               if (slot) begin
                  out_v_q <= 1'b1;
                  out_d_q <= `ACFD_DELIM;
                  st_q <= ACFD_TX_LHI;
               end
            end
            ACFD_TX_LHI: begin
               if (slot) begin
                  out_v_q <= 1'b1;
                  out_d_q <= len_q[15:8];
                  st_q <= ACFD_TX_LLO;
               end
            end
            ACFD_TX_LLO: begin
               if (slot) begin
                  out_v_q <= 1'b1;
                  out_d_q <= len_q[7:0];
                  st_q <= (len_q == 16'h0000) ? ACFD_TX_CSUM : ACFD_TX_DATA;
               end
            end
            ACFD_TX_DATA: begin
               // Caller bytes pass in order: type, id, then name and value, or
               // options, number field then body
               if (take_usr) begin
                  out_v_q <= 1'b1;
                  out_d_q <= usr_data_in;
                  sum_q <= sum_q + usr_data_in;
                  left_q <= left_q - 16'h0001;
                  rdy_q <= 1'b0;
                  if (left_q == 16'h0001) begin
                     st_q <= ACFD_TX_CSUM;
                  end
               end else if (slot) begin
                  rdy_q <= 1'b1;
               end
            end
            ACFD_TX_CSUM: begin
               if (slot) begin
                  out_v_q <= 1'b1;
                  out_d_q <= `ACFD_CSUM_OK - sum_q;
                  st_q <= ACFD_TX_IDLE;
                  busy_q <= 1'b0;
               end
            end
            default: begin
               st_q <= ACFD_TX_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- hdl/acfd_decoder.sv ----
/*
 Device end: receives API frames, checks them and decodes parameter
 requests, queued parameter writes and text-message send requests.
 Assumes the host end on the same clock; no escaping on the link.
// Operation
// - Type 0x08 is immediate parameter request.
// - Immediate request applies its write and queue.
// - Response owed unless frame identifier is zero.
// - Host sends two ASCII name bytes.
// - Value bytes present means write, else read.
// - Type 0x09 writes wait for apply.
// - Queued-type reads answer at once.
// - Both parameter types answer with 0x88.
// - Type 0x1F is text send; plus optional.
// - Status owed unless identifier is zero.
// - Options byte is ignored.
// - Host sends 20-byte zero-ended number.
// - Body follows, at most 160 bytes.
// - Delimiter then big-endian data count.
// - Checksum is 0xFF minus data sum.
// - Bad checksum frames are dropped.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acfd_cfg.svh"
module acfd_decoder
   import acfd_pkg::*;
#(
   parameter int VAL_BYTES = 8,
   parameter int Q_DEPTH = 4
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   acfd_if.dev link,
   output logic cmd_valid_out,
   output logic cmd_write_out,
   output logic cmd_queued_out,
   output logic [7:0] cmd_id_out,
   output logic [15:0] cmd_name_out,
   output logic [8*VAL_BYTES-1:0] cmd_value_out,
   output logic [$clog2(VAL_BYTES+1)-1:0] cmd_vlen_out,
   output logic resp_owed_out,
   output logic [7:0] resp_type_out,
   output logic apply_valid_out,
   output logic [15:0] apply_name_out,
   output logic [8*VAL_BYTES-1:0] apply_value_out,
   output logic [$clog2(VAL_BYTES+1)-1:0] apply_vlen_out,
   output logic sms_valid_out,
   output logic [7:0] sms_id_out,
   output logic status_owed_out,
   output logic [8*`ACFD_NUM_BYTES-1:0] sms_num_out,
   output logic [4:0] sms_num_len_out,
   output logic [7:0] sms_body_len_out,
   input wire logic [7:0] body_addr_in,
   output logic [7:0] body_data_out,
   output logic other_valid_out,
   output logic [7:0] other_type_out,
   output logic bad_frame_out
);
   localparam int VW = 8 * VAL_BYTES;
   localparam int LW = $clog2(VAL_BYTES + 1);
   localparam int QW = $clog2(Q_DEPTH);

   // Refuse sizes the queue pointers and length fields cannot serve
   if (VAL_BYTES < 1 || VAL_BYTES > 64 || Q_DEPTH < 2 ||
       (Q_DEPTH & (Q_DEPTH - 1)) != 0) begin : g_bad_param
      $error("acfd_decoder: unsupported VAL_BYTES or Q_DEPTH");
   end

   // Checksum folds to the target value
   function automatic logic sum_ok(input logic [7:0] s, input logic [7:0] b);
      logic [7:0] t;
      t = s + b;
      return t == `ACFD_CSUM_OK;
   endfunction

   acfd_rx_e st_q; // Receive state
   logic ready_q; // Link ready, low while the queue drains
   logic [15:0] len_q; // Announced frame data count
   logic [15:0] idx_q; // Index of the next data byte
   logic [7:0] sum_q; // Running data sum
   logic [7:0] type_q; // Frame type
   logic [7:0] id_q; // Frame identifier
   logic [15:0] name_q; // Parameter name
   logic [VW-1:0] val_q; // Parameter value, big-endian shift
   logic [LW-1:0] vlen_q; // Value byte count
   logic ovf_q; // A field overran its room
   logic [8*`ACFD_NUM_BYTES-1:0] num_q; // Number field
   logic [4:0] nlen_q; // Characters before the terminator
   logic nend_q; // Terminator seen
   logic [7:0] blen_q; // Body byte count
   logic [7:0] body_mem [`ACFD_BODY_MAX]; // Message body
   // Pending write queue and its pointers
   logic [15:0] qname_mem [Q_DEPTH];
   logic [VW-1:0] qval_mem [Q_DEPTH];
   logic [LW-1:0] qlen_mem [Q_DEPTH];
   logic [QW-1:0] head_q, tail_q;
   logic [QW:0] cnt_q;
   logic drain_q; // Applying the queue
   logic own_v_q; // Immediate write waits behind the queue
   logic [15:0] own_name_q;
   logic [VW-1:0] own_val_q;
   logic [LW-1:0] own_len_q;

   // Byte taken and its decoded place in the frame
   wire take = link.byte_valid && ready_q;
   wire [7:0] b = link.byte_data;
   wire in_data = take && st_q == ACFD_RX_DATA;
   wire in_csum = take && st_q == ACFD_RX_CSUM;
   wire is_imm = type_q == `ACFD_TYPE_IMM;
   wire is_par = is_imm || type_q == `ACFD_TYPE_QUE;
   wire is_sms = type_q == `ACFD_TYPE_SMS;
   wire is_ac = name_q == `ACFD_NAME_APPLY;
   wire [15:0] voff = idx_q - `ACFD_PAR_HDR;
   wire [15:0] noff = idx_q - `ACFD_NUM_FIRST;
   wire [15:0] boff = idx_q - `ACFD_SMS_HDR;
   wire in_num = is_sms && idx_q >= `ACFD_NUM_FIRST &&
      idx_q < `ACFD_SMS_HDR;
   // Outcome of a complete frame
   wire frame_ok = in_csum && sum_ok(sum_q, b) && !ovf_q;
   wire par_ok = frame_ok && is_par && len_q >= `ACFD_PAR_HDR;
   wire sms_ok = frame_ok && is_sms && len_q >= `ACFD_SMS_HDR &&
      nend_q;
   wire oth_ok = frame_ok && !is_par && !is_sms &&
      len_q != 16'h0000;
   wire is_wr = vlen_q != '0;
   wire do_apply = par_ok && (is_imm || is_ac);
   wire do_queue = par_ok && !is_imm && is_wr && !is_ac;
   wire q_full = cnt_q == (QW + 1)'(Q_DEPTH);

   assign link.byte_ready = ready_q;

   // Frame delimiting and checksum accumulation
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_q <= ACFD_RX_IDLE;
         len_q <= 16'h0000;
         idx_q <= 16'h0000;
         sum_q <= 8'h00;
      end else if (take) begin
         case (st_q)
            ACFD_RX_IDLE: begin
               // Anything before a delimiter is dropped
               if (b == `ACFD_DELIM) begin
                  st_q <= ACFD_RX_LHI;
               end
            end
            ACFD_RX_LHI: begin
               len_q <= {b, 8'h00};
               st_q <= ACFD_RX_LLO;
            end
            ACFD_RX_LLO: begin
               len_q <= {len_q[15:8], b};
               idx_q <= 16'h0000;
               sum_q <= 8'h00;
               st_q <= ({len_q[15:8], b} == 16'h0000) ?
                  ACFD_RX_CSUM : ACFD_RX_DATA;
            end
            ACFD_RX_DATA: begin
               sum_q <= sum_q + b;
               idx_q <= idx_q + 16'h0001;
               if (idx_q == len_q - 16'h0001) begin
                  st_q <= ACFD_RX_CSUM;
               end
            end
            default: begin
               st_q <= ACFD_RX_IDLE;
            end
         endcase
      end
   end

   // Field capture; the options byte of a text request is skipped
   always_ff @(posedge mclk_in) begin
      if (rst_in || (take && st_q == ACFD_RX_LLO)) begin
         type_q <= 8'h00;
         id_q <= 8'h00;
         name_q <= 16'h0000;
         val_q <= '0;
         vlen_q <= '0;
         ovf_q <= 1'b0;
         num_q <= '0;
         nlen_q <= 5'h00;
         nend_q <= 1'b0;
         blen_q <= 8'h00;
      end else if (in_data) begin
         if (idx_q == `ACFD_IDX_TYPE) begin
            type_q <= b;
         end else if (idx_q == `ACFD_IDX_ID) begin
            id_q <= b;
         end else if (is_par && idx_q == `ACFD_IDX_NAME_HI) begin
            name_q[15:8] <= b;
         end else if (is_par && idx_q == `ACFD_IDX_NAME_LO) begin
            name_q[7:0] <= b;
         end else if (is_par && voff < 16'(VAL_BYTES)) begin
            val_q <= {val_q[VW-9:0], b};
            vlen_q <= vlen_q + LW'(1);
         end else if (is_par) begin
            ovf_q <= 1'b1;
         end else if (in_num) begin
            // Digits and an optional leading plus are taken as they come
            num_q <= {num_q[8*`ACFD_NUM_BYTES-9:0], b};
            if (b == 8'h00) begin
               nend_q <= 1'b1;
            end else if (!nend_q) begin
               nlen_q <= nlen_q + 5'h01;
            end
         end else if (is_sms && boff < 16'(`ACFD_BODY_MAX)) begin
            blen_q <= blen_q + 8'h01;
         end else if (is_sms && idx_q >= `ACFD_SMS_HDR) begin
            ovf_q <= 1'b1;
         end
      end
   end

   // Body store and registered read port
   always_ff @(posedge mclk_in) begin
      if (in_data && is_sms && !in_num && idx_q >= `ACFD_SMS_HDR &&
          boff < 16'(`ACFD_BODY_MAX)) begin
         body_mem[boff[7:0]] <= b;
      end
      if (rst_in || body_addr_in >= 8'(`ACFD_BODY_MAX)) begin
         body_data_out <= 8'h00;
      end else begin
         body_data_out <= body_mem[body_addr_in];
      end
   end

   // Decoded request outputs, one-cycle pulses with held fields
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cmd_valid_out <= 1'b0;
         cmd_write_out <= 1'b0;
         cmd_queued_out <= 1'b0;
         cmd_id_out <= 8'h00;
         cmd_name_out <= 16'h0000;
         cmd_value_out <= '0;
         cmd_vlen_out <= '0;
         resp_owed_out <= 1'b0;
         resp_type_out <= 8'h00;
         sms_valid_out <= 1'b0;
         sms_id_out <= 8'h00;
         status_owed_out <= 1'b0;
         sms_num_out <= '0;
         sms_num_len_out <= 5'h00;
         sms_body_len_out <= 8'h00;
         other_valid_out <= 1'b0;
         other_type_out <= 8'h00;
         bad_frame_out <= 1'b0;
      end else begin
         cmd_valid_out <= par_ok;
         sms_valid_out <= sms_ok;
         other_valid_out <= oth_ok;
         bad_frame_out <= in_csum && !(par_ok || sms_ok || oth_ok);
         if (par_ok) begin
            // Reads are reported now whatever the type
            cmd_write_out <= is_wr;
            cmd_queued_out <= do_queue;
            cmd_id_out <= id_q;
            cmd_name_out <= name_q;
            cmd_value_out <= val_q;
            cmd_vlen_out <= vlen_q;
            resp_owed_out <= id_q != 8'h00;
            resp_type_out <= `ACFD_TYPE_RESP;
         end
         if (sms_ok) begin
            sms_id_out <= id_q;
            status_owed_out <= id_q != 8'h00;
            sms_num_out <= num_q;
            sms_num_len_out <= nlen_q;
            sms_body_len_out <= blen_q;
         end
         if (oth_ok) begin
            other_type_out <= type_q;
         end
      end
   end

   // Pending queue: fill on queued writes, drain on apply
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         head_q <= '0;
         tail_q <= '0;
         cnt_q <= '0;
         drain_q <= 1'b0;
         own_v_q <= 1'b0;
         own_name_q <= 16'h0000;
         own_val_q <= '0;
         own_len_q <= '0;
         ready_q <= 1'b1;
         apply_valid_out <= 1'b0;
         apply_name_out <= 16'h0000;
         apply_value_out <= '0;
         apply_vlen_out <= '0;
      end else begin
         apply_valid_out <= 1'b0;
         if (do_queue && !q_full) begin
            qname_mem[tail_q] <= name_q;
            qval_mem[tail_q] <= val_q;
            qlen_mem[tail_q] <= vlen_q;
            tail_q <= tail_q + QW'(1);
            cnt_q <= cnt_q + (QW + 1)'(1);
         end
         if (do_apply) begin
            drain_q <= 1'b1;
            ready_q <= 1'b0;
            own_v_q <= is_imm && is_wr && !is_ac;
            own_name_q <= name_q;
            own_val_q <= val_q;
            own_len_q <= vlen_q;
         end else if (drain_q && cnt_q != '0) begin
            // Older queued writes go first
            apply_valid_out <= 1'b1;
            apply_name_out <= qname_mem[head_q];
            apply_value_out <= qval_mem[head_q];
            apply_vlen_out <= qlen_mem[head_q];
            head_q <= head_q + QW'(1);
            cnt_q <= cnt_q - (QW + 1)'(1);
         end else if (drain_q && own_v_q) begin
            apply_valid_out <= 1'b1;
            apply_name_out <= own_name_q;
            apply_value_out <= own_val_q;
            apply_vlen_out <= own_len_q;
            own_v_q <= 1'b0;
         end else if (drain_q) begin
            drain_q <= 1'b0;
            ready_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/acfd_assertions.sv ----
/*
 Checker for the byte link between the host end and the decoder.
 Assumes both ends share mclk_in; sees only the link signals.
*/
`timescale 1ns/1ns
`default_nettype none
module acfd_assertions (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready
);
   logic [2:0] pos_q; // 0 delim, 1 count hi, 2 count lo, 3 data, 4 sum
   logic [15:0] left_q; // Data bytes still owed
   logic [7:0] sum_q; // Running sum of data bytes
   wire logic take; // A byte changes hands
   assign take = byte_valid && byte_ready;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // A taken byte
   sequence s_take;
      byte_valid && byte_ready;
   endsequence
   // The checksum byte of a frame being taken
   sequence s_csum;
      byte_valid && byte_ready && pos_q == 3'd4;
   endsequence
   // Follow the frame position of every taken byte
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pos_q <= 3'd0;
         left_q <= 16'h0000;
         sum_q <= 8'h00;
      end else if (take) begin
         case (pos_q)
            3'd0: pos_q <= 3'd1;
            3'd1: begin
               left_q <= {byte_data, 8'h00};
               pos_q <= 3'd2;
            end
            3'd2: begin
               left_q <= {left_q[15:8], byte_data};
               sum_q <= 8'h00;
               pos_q <= ({left_q[15:8], byte_data} == 16'h0000) ? 3'd4 : 3'd3;
            end
            3'd3: begin
               sum_q <= sum_q + byte_data;
               left_q <= left_q - 16'h0001;
               pos_q <= (left_q == 16'h0001) ? 3'd4 : 3'd3;
            end
            default: pos_q <= 3'd0;
         endcase
      end
   end
   delim_first_a: assert property (
      take && pos_q == 3'd0 |-> byte_data == 8'h7E)
      else $error("frame did not open with the delimiter");
   csum_value_a: assert property (
      s_csum |-> byte_data == 8'hFF - sum_q)
      else $error("checksum byte wrong");
   len_pair_a: assert property (
      take && pos_q == 3'd1 |-> ##[2:8] (take && pos_q == 3'd2))
      else $error("count low byte missing");
   valid_hold_a: assert property (
      byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
      else $error("offered byte not held");
   byte_gap_a: assert property (
      s_take |=> !byte_valid)
      else $error("bytes offered back to back");
   ready_cause_a: assert property (
      $fell(byte_ready) |-> $past(take) && $past(pos_q) == 3'd4)
      else $error("stall without a finished frame");
   ready_back_a: assert property (
      $fell(byte_ready) |-> ##[1:8] byte_ready)
      else $error("apply stall too long");
   reset_idle_a: assert property (
      disable iff (1'b0) rst_in |=> byte_ready && !byte_valid)
      else $error("link not idle after reset");
endmodule
`default_nettype wire

// ---- verif/api_command_frame_decoder_tb.sv ----
/*
 Bench: host end feeds decoder; a raw driver feeds a second decoder.
 Assumes package, header and interface are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acfd_cfg.svh"
module api_command_frame_decoder_tb;
   import acfd_pkg::*;
   localparam int VB = 4; // Value bytes per parameter
   logic mclk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0;
   logic usr_valid_in = 1'b0, usr_ready_out, busy_out;
   logic [15:0] len_in = 16'h0000;
   logic [7:0] usr_data_in = 8'h00, body_addr_in = 8'h00;
   logic cv, cw, cq, ro, av, sv, so, ov, bad, rcv, rbad; // Decoder flags
   logic [7:0] cid, rt, sid, sbl, bdat, ot; // Decoder bytes
   logic [15:0] cnm, an; // Parameter names
   logic [31:0] cval, aval; // Parameter values
   logic [2:0] cvl, avl; // Value counts
   logic [159:0] snum; // Number field
   logic [4:0] snl; // Number length
   logic [7:0] fb[$], ev[$], rb[$]; // Frame, events, raw bytes
   logic [50:0] gotq[$], expq[$], pend_q[$]; // Applies and model queue
   int num_errors = 0, num_checks = 0, cyc = 0, nbad = 0, nrcv = 0;
   acfd_if lnk ();
   acfd_if l2 ();
   acfd_host u_acfd_host (.mclk_in(mclk_in), .rst_in(rst_in), .link(lnk),
      .start_in(start_in), .len_in(len_in), .usr_valid_in(usr_valid_in),
      .usr_data_in(usr_data_in), .usr_ready_out(usr_ready_out),
      .busy_out(busy_out));
   acfd_decoder #(.VAL_BYTES(VB)) u_acfd_decoder (
      .mclk_in(mclk_in), .rst_in(rst_in), .link(lnk), .cmd_valid_out(cv),
      .cmd_write_out(cw), .cmd_queued_out(cq), .cmd_id_out(cid),
      .cmd_name_out(cnm), .cmd_value_out(cval), .cmd_vlen_out(cvl),
      .resp_owed_out(ro), .resp_type_out(rt), .apply_valid_out(av),
      .apply_name_out(an), .apply_value_out(aval), .apply_vlen_out(avl),
      .sms_valid_out(sv), .sms_id_out(sid), .status_owed_out(so),
      .sms_num_out(snum), .sms_num_len_out(snl), .sms_body_len_out(sbl),
      .body_addr_in(body_addr_in), .body_data_out(bdat),
      .other_valid_out(ov), .other_type_out(ot), .bad_frame_out(bad));
   acfd_decoder #(.VAL_BYTES(VB)) u_acfd_decoder_raw (
      .mclk_in(mclk_in), .rst_in(rst_in), .link(l2), .cmd_valid_out(rcv),
      .cmd_write_out(), .cmd_queued_out(), .cmd_id_out(), .cmd_name_out(),
      .cmd_value_out(), .cmd_vlen_out(), .resp_owed_out(),
      .resp_type_out(), .apply_valid_out(), .apply_name_out(),
      .apply_value_out(), .apply_vlen_out(), .sms_valid_out(),
      .sms_id_out(), .status_owed_out(), .sms_num_out(),
      .sms_num_len_out(), .sms_body_len_out(), .body_addr_in(body_addr_in),
      .body_data_out(), .other_valid_out(), .other_type_out(),
      .bad_frame_out(rbad));
   acfd_assertions u_acfd_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
      .byte_valid(lnk.byte_valid), .byte_data(lnk.byte_data),
      .byte_ready(lnk.byte_ready));
   // Clock
   initial forever #25 mclk_in = ~mclk_in;
   // Collect decode pulses once each, mid-cycle
   always @(negedge mclk_in) begin
      if (cv === 1'b1) ev.push_back(8'd1);
      if (sv === 1'b1) ev.push_back(8'd2);
      if (ov === 1'b1) ev.push_back(8'd3);
      if (bad === 1'b1) ev.push_back(8'd4);
      if (av === 1'b1) gotq.push_back({an, aval, avl});
      if (rbad === 1'b1) nbad++;
      if (rcv === 1'b1) nrcv++;
   end
   // Hang guard
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic compare(input logic [159:0] got, input logic [159:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Hand the frame data in fb to the host end, one byte per handshake
   task automatic send();
      int i;
      while (busy_out !== 1'b0) @(negedge mclk_in);
      start_in = 1'b1;
      len_in = 16'(fb.size());
      @(negedge mclk_in);
      start_in = 1'b0;
      for (i = 0; i < fb.size(); i++) begin
         usr_valid_in = 1'b1;
         usr_data_in = fb[i];
         @(posedge mclk_in);
         while (usr_ready_out !== 1'b1) @(posedge mclk_in);
         @(negedge mclk_in);
      end
      usr_valid_in = 1'b0;
   endtask
   // Expect one decode event, then compare the applies seen
   task automatic wait_ev(input logic [7:0] code);
      int n;
      for (n = 0; n < 40 && ev.size() == 0; n++) @(negedge mclk_in);
      compare(ev.size() > 0 ? ev.pop_front() : 8'hEE, code);
      repeat (8) @(negedge mclk_in);
      compare(gotq.size(), expq.size());
      while (expq.size() > 0 && gotq.size() > 0)
         compare(gotq.pop_front(), expq.pop_front());
      gotq = {};
      expq = {};
   endtask
   // Parameter frame with nv random value bytes
   task automatic par(input logic [7:0] ty, input logic [7:0] id,
      input logic [15:0] nm, input int nv);
      logic [31:0] v;
      logic [50:0] rec;
      int i;
      v = 32'h0000_0000;
      fb = {ty, id, nm[15:8], nm[7:0]};
      for (i = 0; i < nv; i++) begin
         fb.push_back(8'($urandom));
         v = {v[23:0], fb[i+4]};
      end
      rec = {nm, v, 3'(nv)};
      // Model: immediate type or apply command drains the queue
      if (ty == 8'h08 || nm == `ACFD_NAME_APPLY) begin
         expq = pend_q;
         pend_q = {};
         if (ty == 8'h08 && nv > 0) expq.push_back(rec);
      end else if (nv > 0 && pend_q.size() < 4) pend_q.push_back(rec);
      send();
      wait_ev(8'd1);
      compare({cw, cq}, {nv > 0, ty == 8'h09 && nv > 0 && nm != `ACFD_NAME_APPLY});
      compare({cid, ro, rt}, {id, id != 8'h00, 8'h88});
      compare({cnm, cval, cvl}, rec);
   endtask
   // Text frame: k number characters, bl body bytes
   task automatic sms(input logic [7:0] id, input logic plus, input int k,
      input int bl);
      logic [159:0] num;
      int i;
      fb = {8'h1F, id, 8'($urandom)};
      for (i = 0; i < 20; i++) begin
         fb.push_back(i >= k ? 8'h00 : (i == 0 && plus) ? 8'h2B : 8'h31);
         num = {num[151:0], fb[i+3]};
      end
      for (i = 0; i < bl; i++) fb.push_back(8'($urandom));
      send();
      wait_ev(8'd2);
      compare({sid, so}, {id, id != 8'h00});
      compare(snum, num);
      compare({snl, sbl}, {5'(k), 8'(bl)});
      for (i = 0; i <= bl; i++) begin
         body_addr_in = (i == bl) ? 8'd160 : 8'(i);
         @(negedge mclk_in);
         compare(bdat, i == bl ? 8'h00 : fb[i+23]);
      end
   endtask
   // Raw byte on the second link; line scrambled once released
   task automatic raw(input logic [7:0] b);
      l2.byte_valid = 1'b1;
      l2.byte_data = b;
      @(posedge mclk_in);
      while (l2.byte_ready !== 1'b1) @(posedge mclk_in);
      @(negedge mclk_in);
      l2.byte_valid = 1'b0;
      l2.byte_data = ~b;
      @(negedge mclk_in);
   endtask
   // Main sequence
   initial begin
      int i;
      logic [7:0] cs;
      l2.byte_valid = 1'b0;
      l2.byte_data = 8'h00;
      void'($urandom(32'h5462ed9c));
      repeat (4) @(negedge mclk_in);
      rst_in = 1'b0;
      for (i = 0; i < 5; i++)
         par(8'h09, 8'($urandom % 255 + 1), 16'h4E30 + 16'(i), i % 4 + 1);
      fb = {8'h20, 8'h01, 8'h55};
      send();
      wait_ev(8'd3);
      compare(ot, 8'h20);
      par(8'h08, 8'h07, 16'h4E49, 0);
      par(8'h09, 8'h00, 16'h4E52, 0);
      par(8'h09, 8'h09, 16'h4E42, 3);
      par(8'h09, 8'h0A, `ACFD_NAME_APPLY, 0);
      par(8'h08, 8'h00, 16'h4E43, 4);
      sms(8'h21, 1'b1, 19, 160);
      sms(8'h00, 1'b0, 7, 1 + $urandom % 40);
      rb = {8'h55, 8'h7E, 8'h00, 8'h04, 8'h08, 8'h05, 8'h4E, 8'h49};
      cs = 8'hFF - 8'(8'h08 + 8'h05 + 8'h4E + 8'h49);
      for (i = 0; i < 2; i++) begin
         foreach (rb[j]) raw(rb[j]);
         raw(cs + 8'(1 - i));
         repeat (10) @(negedge mclk_in);
      end
      compare({8'(nbad), 8'(nrcv)}, {8'd1, 8'd1});
      summarize();
   end
endmodule
`default_nettype wire
